// file: common/dclso_pkg.sv
// What this block does
// RL1: Each channel's samples leave serialized on its lane-1 pair, timed to the output clock.
// RL2: Single-lane mode sends every sample of a channel in order on lane 1.
// RL3: Dual-lane mode sends only every second sample of a channel on lane 1.
// RL4: Dual-lane mode sends the other alternate samples serialized on lane 0.
// RL5: Single-lane mode keeps both lane-0 outputs in high impedance.
// RL6: Power-down freezes every data lane at its last driven level.
// RL7: Active data lanes stay enabled while powered up; no enable control exists.
// RL8: Serial-interface enable high: mode pins ignored, configuration from control registers.
// RL9: One bit per lane on each rising and falling output clock edge.
// RL10: Every lane-1 word of both channels starts at a frame rising edge.
// RL11: In dual-lane mode each lane-0 word starts at a frame falling edge.
// RL12: Serial-interface enable low: control interface disabled, mode pins obeyed.
// RL13: Each sample is a fixed 14-bit word, same bit order on every lane.
package dclso_pkg;

   localparam int DCLSO_WORD_W = 14;
   localparam int DCLSO_ADDR_W = 8;
   localparam int DCLSO_DATA_W = 32;

   localparam logic [DCLSO_ADDR_W-1:0] DCLSO_CTRL_OFS = 8'h00;
   localparam logic [DCLSO_ADDR_W-1:0] DCLSO_STAT_OFS = 8'h04;

   localparam int DCLSO_CTRL_DUAL_BIT = 0;
   localparam int DCLSO_CTRL_PD_BIT = 1;
   localparam int DCLSO_STAT_DUAL_BIT = 0;
   localparam int DCLSO_STAT_PD_BIT = 1;
   localparam int DCLSO_STAT_SPI_BIT = 2;
   localparam int DCLSO_STAT_UNDR_BIT = 3;

   localparam logic [1:0] DCLSO_CTRL_RST = 2'h0;
   // Link side starts powered down until the first configuration arrives
   localparam logic [1:0] DCLSO_CFG_SYNC_RST = 2'h1;

   localparam logic [1:0] DCLSO_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCLSO_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      DCLSO_SEL_CTRL = 3'b001,
      DCLSO_SEL_STAT = 3'b010,
      DCLSO_SEL_NONE = 3'b100
   } dclso_sel_type;

   typedef enum logic [1:0] {
      DCLSO_ST_OFF = 2'b01,
      DCLSO_ST_RUN = 2'b10
   } dclso_state_type;

   function automatic dclso_sel_type dclso_reg_sel(input logic [DCLSO_ADDR_W-1:0] addr);
      dclso_sel_type sel;
      sel = DCLSO_SEL_NONE;
      if (addr[DCLSO_ADDR_W-1:2] == DCLSO_CTRL_OFS[DCLSO_ADDR_W-1:2]) begin
         sel = DCLSO_SEL_CTRL;
      end else if (addr[DCLSO_ADDR_W-1:2] == DCLSO_STAT_OFS[DCLSO_ADDR_W-1:2]) begin
         sel = DCLSO_SEL_STAT;
      end
      return sel;
   endfunction

endpackage

// file: src/dclso_sync.sv
`timescale 1ns/1ps
module dclso_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // The first stage feeds only the second one
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule

// file: src/dclso_top.sv
`timescale 1ns/1ps
module dclso_top
   import dclso_pkg::*;
#(
   parameter int WORD_W = DCLSO_WORD_W
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic LINK_CLK,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [DCLSO_ADDR_W-1:0] AWADDR,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [DCLSO_DATA_W-1:0] WDATA,
   input wire logic [3:0] WSTRB,
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [DCLSO_ADDR_W-1:0] ARADDR,
   output logic RVALID,
   input wire logic RREADY,
   output logic [DCLSO_DATA_W-1:0] RDATA,
   output logic [1:0] RRESP,
   input wire logic [WORD_W-1:0] SMP_A,
   input wire logic [WORD_W-1:0] SMP_B,
   input wire logic SMP_VALID,
   output logic SMP_READY,
   input wire logic SERIAL_CTRL_EN,
   input wire logic DUAL_LANE_PIN_N,
   input wire logic POWER_DOWN_PIN,
   output logic CHAN_A_LANE1_OUT,
   output logic CHAN_B_LANE1_OUT,
   output logic CHAN_A_LANE0_OUT,
   output logic CHAN_A_LANE0_OE,
   output logic CHAN_B_LANE0_OUT,
   output logic CHAN_B_LANE0_OE,
   output logic FORWARDED_BIT_CLOCK,
   output logic FRAME_OUT
);
   localparam int CW = $clog2(WORD_W);
   localparam logic [CW-1:0] LAST = CW'(WORD_W - 1);
   localparam logic [CW-1:0] HALF = CW'(WORD_W / 2);

   generate
      if (WORD_W < 4 || (WORD_W % 2) != 0) begin : g_bad_width
         $error("WORD_W must be even and at least 4");
      end
   endgenerate

   // ---------------- Register clock domain ----------------
   logic [2:0] pin_s;
   logic spi_s;
   logic ack_s;
   logic undr_s;
   logic undr_seen_r;
   logic undr_evt;
   logic [1:0] ctrl_r;
   logic eff_dual_r;
   logic eff_pd_r;
   logic undr_flag_r;
   logic req_tgl_r;
   logic smp_ready_r;
   logic [WORD_W-1:0] hold_r [2];
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [DCLSO_ADDR_W-1:0] awaddr_r;
   logic [DCLSO_DATA_W-1:0] wdata_r;
   logic [3:0] wstrb_r;
   logic arready_r;
   logic rvalid_r;
   logic [DCLSO_DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_go;
   dclso_sel_type wr_sel;
   dclso_sel_type rd_sel;
   logic [DCLSO_DATA_W-1:0] rd_data;

   // Reset value matches idle pins (single lane, powered up) so no false dual mode after reset
   dclso_sync #(.W(3), .RST_VAL(3'h2)) u_pin_sync (
      .clk(MCLK),
      .rst_b(RST_B),
      .d({SERIAL_CTRL_EN, DUAL_LANE_PIN_N, POWER_DOWN_PIN}),
      .q(pin_s)
   );
   assign spi_s = pin_s[2];

   // Source of configuration follows the enable pin
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         eff_dual_r <= 1'b0;
         eff_pd_r <= 1'b0;
      end else if (spi_s) begin
         eff_dual_r <= ctrl_r[DCLSO_CTRL_DUAL_BIT]; // [RL8]
         eff_pd_r <= ctrl_r[DCLSO_CTRL_PD_BIT]; // [RL8]
      end else begin
         eff_dual_r <= !pin_s[1]; // [RL12]
         eff_pd_r <= pin_s[0]; // [RL12]
      end
   end

   // Sample capture; the hold words stay put until the link acknowledges
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         req_tgl_r <= 1'b0;
         smp_ready_r <= 1'b1;
         hold_r[0] <= '0;
         hold_r[1] <= '0;
      end else if (smp_ready_r && SMP_VALID) begin
         hold_r[0] <= SMP_A;
         hold_r[1] <= SMP_B;
         req_tgl_r <= ~req_tgl_r;
         smp_ready_r <= 1'b0;
      end else if (!smp_ready_r && (ack_s == req_tgl_r)) begin
         smp_ready_r <= 1'b1;
      end
   end

   // AXI4-Lite write channel
   assign wr_go = !awready_r && !wready_r && !bvalid_r;
   assign wr_sel = dclso_reg_sel(awaddr_r);

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= DCLSO_RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (AWVALID && awready_r) begin
            awaddr_r <= AWADDR;
            awready_r <= 1'b0;
         end
         if (WVALID && wready_r) begin
            wdata_r <= WDATA;
            wstrb_r <= WSTRB;
            wready_r <= 1'b0;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == DCLSO_SEL_NONE) ? DCLSO_RESP_SLVERR : DCLSO_RESP_OKAY;
         end
         if (bvalid_r && BREADY) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Control writes are dropped while the control interface is disabled
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         ctrl_r <= DCLSO_CTRL_RST;
      end else if (wr_go && wr_sel == DCLSO_SEL_CTRL && wstrb_r[0] && spi_s) begin // [RL12]
         ctrl_r <= wdata_r[1:0];
      end
   end

   // Underrun flag: a new event wins over a simultaneous clear
   assign undr_evt = undr_s ^ undr_seen_r;
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         undr_seen_r <= 1'b0;
         undr_flag_r <= 1'b0;
      end else begin
         undr_seen_r <= undr_s;
         if (undr_evt) begin
            undr_flag_r <= 1'b1;
         end else if (wr_go && wr_sel == DCLSO_SEL_STAT && wstrb_r[0]
                      && wdata_r[DCLSO_STAT_UNDR_BIT]) begin
            undr_flag_r <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   assign rd_sel = dclso_reg_sel(ARADDR);
   always_comb begin
      rd_data = '0;
      case (rd_sel)
         DCLSO_SEL_CTRL: begin
            rd_data[1:0] = ctrl_r;
         end
         DCLSO_SEL_STAT: begin
            rd_data[DCLSO_STAT_DUAL_BIT] = eff_dual_r;
            rd_data[DCLSO_STAT_PD_BIT] = eff_pd_r;
            rd_data[DCLSO_STAT_SPI_BIT] = spi_s;
            rd_data[DCLSO_STAT_UNDR_BIT] = undr_flag_r;
         end
         default: begin
            rd_data = '0;
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= DCLSO_RESP_OKAY;
      end else if (ARVALID && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_data;
         rresp_r <= (rd_sel == DCLSO_SEL_NONE) ? DCLSO_RESP_SLVERR : DCLSO_RESP_OKAY;
      end else if (rvalid_r && RREADY) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ---------------- Link clock domain ----------------
   logic link_rst_b;
   logic [1:0] cfg_l;
   logic req_l;
   dclso_state_type st_r;
   logic [CW-1:0] cnt_r;
   logic [1:0] pcnt_r;
   logic [WORD_W-1:0] pend_r [2][2];
   logic ack_tgl_r;
   logic undr_tgl_r;
   logic dual_w_r;
   logic l0_oe_r;
   logic fwd_clk_r;
   logic frame_r;
   logic run_go;
   logic word_go;
   logic half_go;
   logic avail;
   logic take;

   // Reset follows RST_B into the link domain; LINK_CLK must run during reset
   dclso_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
      .clk(LINK_CLK),
      .rst_b(1'b1),
      .d(RST_B),
      .q(link_rst_b)
   );
   dclso_sync #(.W(2), .RST_VAL(DCLSO_CFG_SYNC_RST)) u_cfg_sync (
      .clk(LINK_CLK),
      .rst_b(link_rst_b),
      .d({eff_dual_r, eff_pd_r}),
      .q(cfg_l)
   );
   dclso_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
      .clk(LINK_CLK),
      .rst_b(link_rst_b),
      .d(req_tgl_r),
      .q(req_l)
   );
   dclso_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
      .clk(MCLK),
      .rst_b(RST_B),
      .d(ack_tgl_r),
      .q(ack_s)
   );
   dclso_sync #(.W(1), .RST_VAL(1'b0)) u_undr_sync (
      .clk(MCLK),
      .rst_b(RST_B),
      .d(undr_tgl_r),
      .q(undr_s)
   );

   assign run_go = (st_r == DCLSO_ST_RUN) && !cfg_l[0];
   assign word_go = run_go && (cnt_r == '0);
   assign half_go = run_go && (cnt_r == HALF);
   assign avail = cfg_l[1] ? (pcnt_r == 2'h2) : (pcnt_r != 2'h0);
   // Loads happen away from the word boundary so a slot is never filled and drained at once
   assign take = (req_l != ack_tgl_r) && (pcnt_r != 2'h2) && !word_go;

   always_ff @(posedge LINK_CLK) begin
      if (!link_rst_b) begin
         st_r <= DCLSO_ST_OFF;
         cnt_r <= '0;
         fwd_clk_r <= 1'b0;
         frame_r <= 1'b0;
      end else begin
         case (st_r)
            DCLSO_ST_OFF: begin
               fwd_clk_r <= 1'b0;
               frame_r <= 1'b0;
               cnt_r <= '0;
               if (!cfg_l[0]) begin
                  st_r <= DCLSO_ST_RUN;
               end
            end
            DCLSO_ST_RUN: begin
               if (cfg_l[0]) begin
                  st_r <= DCLSO_ST_OFF; // [RL6]
               end else begin
                  fwd_clk_r <= ~fwd_clk_r; // [RL9]
                  frame_r <= (cnt_r < HALF); // [RL10] [RL11]
                  cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1); // [RL13]
               end
            end
            default: begin
               st_r <= DCLSO_ST_OFF;
            end
         endcase
      end
   end

   // Two-deep sample store; dual-lane words need a pair, single-lane one
   always_ff @(posedge LINK_CLK) begin
      if (!link_rst_b) begin
         pcnt_r <= 2'h0;
         ack_tgl_r <= 1'b0;
         undr_tgl_r <= 1'b0;
         for (int c = 0; c < 2; c++) begin
            pend_r[c][0] <= '0;
            pend_r[c][1] <= '0;
         end
      end else if (take) begin
         // Hold words are stable here: MCLK side waits for the acknowledge
         for (int c = 0; c < 2; c++) begin
            pend_r[c][pcnt_r[0]] <= hold_r[c];
         end
         pcnt_r <= pcnt_r + 2'h1;
         ack_tgl_r <= req_l;
      end else if (word_go) begin
         if (!avail) begin
            undr_tgl_r <= ~undr_tgl_r;
         end else if (cfg_l[1]) begin
            pcnt_r <= 2'h0; // [RL3]
         end else begin
            for (int c = 0; c < 2; c++) begin
               pend_r[c][0] <= pend_r[c][1]; // [RL2]
            end
            pcnt_r <= pcnt_r - 2'h1;
         end
      end
   end

   // Lane mode is switched only at a word boundary
   always_ff @(posedge LINK_CLK) begin
      if (!link_rst_b) begin
         dual_w_r <= 1'b0;
         l0_oe_r <= 1'b0;
      end else if (word_go) begin
         dual_w_r <= cfg_l[1];
         l0_oe_r <= cfg_l[1]; // [RL5] [RL7]
      end
   end

   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         logic [WORD_W-1:0] w1;
         logic [WORD_W-1:0] l1_word_r;
         logic [WORD_W-1:0] l1_sh_r;
         logic l1_out_r;
         logic [WORD_W-1:0] l0_next_r;
         logic [WORD_W-1:0] l0_sh_r;
         logic l0_out_r;

         // On underrun the previous word repeats so the frame never breaks
         assign w1 = avail ? pend_r[c][0] : l1_word_r;

         always_ff @(posedge LINK_CLK) begin
            if (!link_rst_b) begin
               l1_word_r <= '0;
               l1_sh_r <= '0;
               l1_out_r <= 1'b0;
               l0_next_r <= '0;
            end else if (word_go) begin
               l1_word_r <= w1; // [RL2] [RL3]
               l1_out_r <= w1[WORD_W-1]; // [RL1] [RL10]
               l1_sh_r <= {w1[WORD_W-2:0], 1'b0};
               if (cfg_l[1] && avail) begin
                  l0_next_r <= pend_r[c][1]; // [RL4]
               end
            end else if (run_go) begin
               l1_out_r <= l1_sh_r[WORD_W-1]; // [RL1] [RL13]
               l1_sh_r <= {l1_sh_r[WORD_W-2:0], 1'b0};
            end
         end

         // Lane 0 runs half a word behind lane 1; idle lanes keep their level
         always_ff @(posedge LINK_CLK) begin
            if (!link_rst_b) begin
               l0_sh_r <= '0;
               l0_out_r <= 1'b0;
            end else if (half_go && dual_w_r) begin
               l0_out_r <= l0_next_r[WORD_W-1]; // [RL4] [RL11]
               l0_sh_r <= {l0_next_r[WORD_W-2:0], 1'b0};
            end else if (run_go && dual_w_r) begin
               l0_out_r <= l0_sh_r[WORD_W-1]; // [RL4]
               l0_sh_r <= {l0_sh_r[WORD_W-2:0], 1'b0};
            end
         end
      end
   endgenerate

   assign AWREADY = awready_r;
   assign WREADY = wready_r;
   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;
   assign ARREADY = arready_r;
   assign RVALID = rvalid_r;
   assign RDATA = rdata_r;
   assign RRESP = rresp_r;
   assign SMP_READY = smp_ready_r;
   assign CHAN_A_LANE1_OUT = g_ch[0].l1_out_r;
   assign CHAN_B_LANE1_OUT = g_ch[1].l1_out_r;
   assign CHAN_A_LANE0_OUT = g_ch[0].l0_out_r;
   assign CHAN_B_LANE0_OUT = g_ch[1].l0_out_r;
   assign CHAN_A_LANE0_OE = l0_oe_r;
   assign CHAN_B_LANE0_OE = l0_oe_r;
   assign FORWARDED_BIT_CLOCK = fwd_clk_r;
   assign FRAME_OUT = frame_r;

   // ---------------- Checks ----------------
   lane1_bits_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL1]
      (run_go && cnt_r != '0) |=> CHAN_A_LANE1_OUT == $past(g_ch[0].l1_sh_r[WORD_W-1]))
      else $error("lane 1 bit does not follow its shift word");
   single_order_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL2]
      (word_go && !cfg_l[1] && pcnt_r != 2'h0) |=> g_ch[0].l1_word_r == $past(pend_r[0][0]))
      else $error("single lane skipped the oldest sample");
   dual_split_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL3]
      (word_go && cfg_l[1] && pcnt_r == 2'h2) |=>
         (g_ch[1].l1_word_r == $past(pend_r[1][0])) && (g_ch[1].l0_next_r == $past(pend_r[1][1])))
      else $error("dual lane did not split the sample pair");
   lane0_start_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL4]
      (half_go && dual_w_r) |=> CHAN_A_LANE0_OUT == $past(g_ch[0].l0_next_r[WORD_W-1]))
      else $error("lane 0 word did not start with its top bit");
   lane0_float_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL5]
      (word_go && !cfg_l[1]) |=> !CHAN_A_LANE0_OE && !CHAN_B_LANE0_OE)
      else $error("lane 0 driven in single lane mode");
   pd_freeze_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL6]
      (st_r == DCLSO_ST_OFF) |=> $stable({CHAN_A_LANE1_OUT, CHAN_B_LANE1_OUT,
                                          CHAN_A_LANE0_OUT, CHAN_B_LANE0_OUT}))
      else $error("data lane moved during power down");
   lane_enable_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL7]
      (dual_w_r && cfg_l[1]) |=> CHAN_A_LANE0_OE && CHAN_B_LANE0_OE)
      else $error("active lane 0 lost its enable");
   spi_cfg_a: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL8]
      spi_s |=> (eff_dual_r == $past(ctrl_r[DCLSO_CTRL_DUAL_BIT]))
                && (eff_pd_r == $past(ctrl_r[DCLSO_CTRL_PD_BIT])))
      else $error("mode pins used while control interface enabled");
   ddr_clock_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL9]
      run_go |=> FORWARDED_BIT_CLOCK != $past(FORWARDED_BIT_CLOCK))
      else $error("output clock missed an edge for a bit");
   frame_rise_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL10]
      word_go |=> $rose(FRAME_OUT) && CHAN_B_LANE1_OUT == $past(g_ch[1].w1[WORD_W-1]))
      else $error("lane 1 word not aligned to frame rise");
   frame_fall_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL11]
      half_go |=> $fell(FRAME_OUT))
      else $error("frame did not fall at half word");
   pin_cfg_a: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL12]
      !spi_s |=> (eff_dual_r == !$past(pin_s[1])) && (eff_pd_r == $past(pin_s[0])))
      else $error("mode pins not obeyed with control interface off");
   word_len_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_b) // [RL13]
      (run_go && cnt_r == LAST) |=> (cnt_r == '0) && FRAME_OUT == 1'b0)
      else $error("word length is not the fixed width");

   single_word_c: cover property (@(posedge LINK_CLK) disable iff (!link_rst_b)
      word_go && !cfg_l[1] && avail);
   dual_word_c: cover property (@(posedge LINK_CLK) disable iff (!link_rst_b)
      word_go && cfg_l[1] && avail);
   pd_entry_c: cover property (@(posedge LINK_CLK) disable iff (!link_rst_b)
      st_r == DCLSO_ST_RUN && cfg_l[0]);
   underrun_c: cover property (@(posedge LINK_CLK) disable iff (!link_rst_b)
      word_go && !avail);
endmodule

// file: dv/dclso_rx_model.sv
`timescale 1ns/1ps
module dclso_rx_model (
   input wire logic link_clk,
   input wire logic bit_clk,
   input wire logic frame,
   input wire logic a1,
   input wire logic b1,
   input wire logic a0,
   input wire logic b0,
   input wire logic oe
);
   logic [13:0] qa[$];
   logic [13:0] qb[$];
   logic [13:0] sa1_r, sb1_r, sa0_r, sb0_r;
   logic [3:0] last_r;
   logic ck_r = 1'b0;
   logic fr_r = 1'b0;
   logic l0_r = 1'b0;
   int k_r = 99;
   // Mid-bit sampling stands in for the receiver's phase-shifted capture on both edges
   always @(negedge link_clk) begin
      if (bit_clk !== ck_r) begin
         sa1_r = {sa1_r[12:0], a1};
         sb1_r = {sb1_r[12:0], b1};
         sa0_r = {sa0_r[12:0], a0};
         sb0_r = {sb0_r[12:0], b0};
         last_r = {a1, b1, a0, b0};
         k_r = (frame && !fr_r) ? 0 : k_r + 1;
         if (k_r == 13) begin
            qa.push_back(sa1_r);
            qb.push_back(sb1_r);
         end
         if (k_r == 7) begin
            l0_r = oe;
         end
         // Lane-0 word spans into the next frame, so samples stay in order
         if (k_r == 6 && l0_r && oe) begin
            qa.push_back(sa0_r);
            qb.push_back(sb0_r);
            l0_r = 1'b0;
         end
      end
      ck_r = bit_clk;
      fr_r = frame;
   end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dclso_pkg::*;
   logic MCLK = 1'b0;
   logic LINK_CLK = 1'b0;
   logic RST_B = 1'b0;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic SMP_VALID = 1'b0, SERIAL_CTRL_EN = 1'b0, DUAL_LANE_PIN_N = 1'b1, POWER_DOWN_PIN = 1'b0;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA, d;
   logic [3:0] WSTRB = 4'hf;
   logic [13:0] SMP_A = 14'h0, SMP_B = 14'h0;
   logic [1:0] BRESP, RRESP;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SMP_READY, FORWARDED_BIT_CLOCK, FRAME_OUT;
   logic CHAN_A_LANE1_OUT, CHAN_B_LANE1_OUT, CHAN_A_LANE0_OUT, CHAN_B_LANE0_OUT;
   logic CHAN_A_LANE0_OE, CHAN_B_LANE0_OE;
   logic [13:0] sa[$];
   logic [13:0] sb[$];
   int miscompares = 0, comparisons = 0, cyc = 0;
   int seed = 32'hb98f0253;

   always #12.5 MCLK = ~MCLK;
   initial begin
      #7;
      forever #16 LINK_CLK = ~LINK_CLK;
   end

   dclso_top dut_u (.MCLK, .RST_B, .LINK_CLK, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
      .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY,
      .RDATA, .RRESP, .SMP_A, .SMP_B, .SMP_VALID, .SMP_READY, .SERIAL_CTRL_EN, .DUAL_LANE_PIN_N,
      .POWER_DOWN_PIN, .CHAN_A_LANE1_OUT, .CHAN_B_LANE1_OUT, .CHAN_A_LANE0_OUT, .CHAN_A_LANE0_OE,
      .CHAN_B_LANE0_OUT, .CHAN_B_LANE0_OE, .FORWARDED_BIT_CLOCK, .FRAME_OUT);

   dclso_rx_model rx_u (.link_clk(LINK_CLK), .bit_clk(FORWARDED_BIT_CLOCK), .frame(FRAME_OUT),
      .a1(CHAN_A_LANE1_OUT), .b1(CHAN_B_LANE1_OUT), .a0(CHAN_A_LANE0_OUT),
      .b0(CHAN_B_LANE0_OUT), .oe(CHAN_A_LANE0_OE));

   task print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task step(input int n);
      repeat (n) @(posedge MCLK);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      // Let an edge pass so a ready released by the previous call is not raised in the same step
      @(posedge MCLK);
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      AWADDR <= a;
      WDATA <= v;
      BREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         if (AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WREADY === 1'b1) WVALID <= 1'b0;
      end while (BVALID !== 1'b1);
      chk(BRESP, r);
      BREADY <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [1:0] r);
      @(posedge MCLK);
      ARVALID <= 1'b1;
      ARADDR <= a;
      RREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         if (ARREADY === 1'b1) ARVALID <= 1'b0;
      end while (RVALID !== 1'b1);
      d = RDATA;
      chk(RRESP, r);
      RREADY <= 1'b0;
   endtask

   task send1;
      logic [31:0] r;
      r = $random(seed);
      SMP_A <= r[13:0];
      SMP_B <= r[29:16];
      SMP_VALID <= 1'b1;
      do @(posedge MCLK); while (SMP_READY !== 1'b1);
      sa.push_back(r[13:0]);
      sb.push_back(r[29:16]);
   endtask

   // Earlier words and underrun repeats precede the stream, so align on its first word
   task match(input logic [13:0] s[$], input logic [13:0] q[$]);
      int i;
      i = 0;
      while (i < q.size() && q[i] !== s[0]) i++;
      foreach (s[j]) chk(i + j < q.size() ? q[i + j] : 14'hx, s[j]);
   endtask

   task run(input int n, input logic dl);
      sa.delete();
      sb.delete();
      rx_u.qa.delete();
      rx_u.qb.delete();
      repeat (n) send1();
      SMP_VALID <= 1'b0;
      step(80);
      match(sa, rx_u.qa);
      match(sb, rx_u.qb);
      chk(CHAN_A_LANE0_OE, dl);
      chk(CHAN_B_LANE0_OE, dl);
      $display("stream test dual=%0d done", dl);
   endtask

   task pdchk;
      step(30);
      chk({CHAN_A_LANE1_OUT, CHAN_B_LANE1_OUT, CHAN_A_LANE0_OUT, CHAN_B_LANE0_OUT},
          rx_u.last_r);
      step(40);
      chk({CHAN_A_LANE1_OUT, CHAN_B_LANE1_OUT, CHAN_A_LANE0_OUT, CHAN_B_LANE0_OUT, FRAME_OUT,
           FORWARDED_BIT_CLOCK}, {rx_u.last_r, 2'b00});
      rd(8'h04, DCLSO_RESP_OKAY);
      chk(d[1], 1'b1);
      $display("power-down test done");
   endtask

   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   initial begin
      step(16);
      RST_B <= 1'b1;
      step(40);
      rd(8'h00, DCLSO_RESP_OKAY);
      chk(d, 32'h0);
      rd(8'h08, DCLSO_RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h40, 32'h1, DCLSO_RESP_SLVERR);
      wr(8'h00, 32'h3, DCLSO_RESP_OKAY);
      rd(8'h00, DCLSO_RESP_OKAY);
      chk(d, 32'h0);
      rd(8'h04, DCLSO_RESP_OKAY);
      chk(d[2:0], 3'h0);
      chk(d[3], 1'b1);
      $display("register test done");
      run(16, 1'b0);
      DUAL_LANE_PIN_N <= 1'b0;
      step(100);
      run(16, 1'b1);
      POWER_DOWN_PIN <= 1'b1;
      pdchk();
      POWER_DOWN_PIN <= 1'b0;
      step(100);
      // Pins now ask for dual lane and power down; registers must win
      SERIAL_CTRL_EN <= 1'b1;
      POWER_DOWN_PIN <= 1'b1;
      step(10);
      rd(8'h04, DCLSO_RESP_OKAY);
      chk(d[2:0], 3'h4);
      // Control write without byte lane 0 must leave the register alone
      WSTRB <= 4'he;
      wr(8'h00, 32'h1, DCLSO_RESP_OKAY);
      WSTRB <= 4'hf;
      rd(8'h00, DCLSO_RESP_OKAY);
      chk(d, 32'h0);
      step(100);
      run(16, 1'b0);
      wr(8'h00, 32'h1, DCLSO_RESP_OKAY);
      step(100);
      run(16, 1'b1);
      wr(8'h00, 32'h2, DCLSO_RESP_OKAY);
      pdchk();
      SERIAL_CTRL_EN <= 1'b0;
      POWER_DOWN_PIN <= 1'b0;
      step(10);
      rd(8'h04, DCLSO_RESP_OKAY);
      chk(d[2:0], 3'h1);
      step(100);
      run(16, 1'b1);
      print_verdict();
   end
endmodule
